// *** rsc_exec.sv ***
// Decode and execute of or-immediate, control read, previous-set read,
// return, rotates and register shift left. Sits between fetch and the
// register file; all neighbours run on mclk, so no input is synchronised.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: ori zero-extends immediate, ORs into B
// RULE2: rdctl copies control register; supervisor only
// RULE3: rdprs adds signed immediate to previous A
// RULE4: previous set from tracked status field
// RULE5: no shadow sets illegal; else supervisor only
// RULE6: ret loads PC from return address
// RULE7: misaligned return target raises exception
// RULE8: rol by low five bits of B
// RULE9: roli by five-bit immediate into C
// RULE10: ror by low five bits of B
// RULE11: sll zero fills, writes C
// RULE12: decode primary and extended opcode fields
module rsc_exec
(
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        issue_valid,
  input  wire logic [rsc_pkg::WORD_W-1:0]  issue_instr,
  input  wire logic                        supervisor,
  input  wire logic                        shadow_sets_present,
  input  wire logic [rsc_pkg::WORD_W-1:0]  source_reg_a,
  input  wire logic [rsc_pkg::WORD_W-1:0]  source_reg_b,
  input  wire logic [rsc_pkg::WORD_W-1:0]  prev_reg_a,
  input  wire logic [rsc_pkg::WORD_W-1:0]  control_reg_n,
  input  wire logic                        set_switch,
  input  wire logic [rsc_pkg::SET_W-1:0]   set_switch_to,
  input  wire logic                        prs_write,
  input  wire logic [rsc_pkg::SET_W-1:0]   prs_write_value,
  output      logic                        issue_ready,
  output      logic [rsc_pkg::IDX_W-1:0]   rd_idx_a,
  output      logic [rsc_pkg::IDX_W-1:0]   rd_idx_b,
  output      logic [rsc_pkg::SET_W-1:0]   rd_prev_set,
  output      logic [rsc_pkg::IDX_W-1:0]   ctl_idx,
  output      logic [rsc_pkg::SET_W-1:0]   cur_set,
  output      logic                        done,
  output      logic                        unsupported,
  output      rsc_pkg::rsc_wb_t            wb,
  output      logic                        pc_load,
  output      logic [rsc_pkg::WORD_W-1:0]  pc_target,
  output      logic                        exc_valid,
  output      rsc_pkg::rsc_exc_t           exc_cause
);

  // ------------------------------------------------------------------
  // Storage and next values
  // ------------------------------------------------------------------
  rsc_pkg::rsc_state_t            state;
  rsc_pkg::rsc_state_t            next_state;
  rsc_pkg::rsc_dec_t              dec;
  rsc_pkg::rsc_dec_t              next_dec;
  rsc_pkg::rsc_dec_t              dec_now;
  logic                           next_issue_ready;
  logic [rsc_pkg::IDX_W-1:0]      next_rd_idx_a;
  logic [rsc_pkg::IDX_W-1:0]      next_rd_idx_b;
  logic [rsc_pkg::SET_W-1:0]      next_rd_prev_set;
  logic [rsc_pkg::IDX_W-1:0]      next_ctl_idx;
  logic                           next_done;
  logic                           next_unsupported;
  rsc_pkg::rsc_wb_t               next_wb;
  logic                           next_pc_load;
  logic [rsc_pkg::WORD_W-1:0]     next_pc_target;
  logic                           next_exc_valid;
  rsc_pkg::rsc_exc_t              next_exc_cause;
  logic [rsc_pkg::SET_W-1:0]      prev_set;
  logic [rsc_pkg::WORD_W-1:0]     shift_out;
  logic [rsc_pkg::IDX_W-1:0]      shift_amount;
  rsc_pkg::rsc_shift_t            shift_kind;
  logic [rsc_pkg::OP_W-1:0]       op_field;
  logic [rsc_pkg::OP_W-1:0]       opx_field;
  logic [rsc_pkg::WORD_W-1:0]     imm_zext;
  logic [rsc_pkg::WORD_W-1:0]     imm_sext;

  // ------------------------------------------------------------------
  // Register set tracking and shifter
  // ------------------------------------------------------------------
  rsc_set_track u_set_track
  (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .set_switch      (set_switch),
    .set_switch_to   (set_switch_to),
    .prs_write       (prs_write),
    .prs_write_value (prs_write_value),
    .cur_set         (cur_set),
    .prev_set        (prev_set)
  );

  rsc_shifter u_shifter
  (
    .value  (source_reg_a),
    .amount (shift_amount),
    .kind   (shift_kind),
    .result (shift_out)
  );

  // ------------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------------
  always_comb
  begin
    op_field  = issue_instr[rsc_pkg::OP_LSB +: rsc_pkg::OP_W];
    opx_field = issue_instr[rsc_pkg::OPX_LSB +: rsc_pkg::OP_W];
    dec_now.a = issue_instr[rsc_pkg::A_LSB +: rsc_pkg::IDX_W];
    dec_now.b = issue_instr[rsc_pkg::B_LSB +: rsc_pkg::IDX_W];
    dec_now.c = issue_instr[rsc_pkg::C_LSB +: rsc_pkg::IDX_W];
    dec_now.immediate_5 =
      issue_instr[rsc_pkg::IMMEDIATE_5_LSB +: rsc_pkg::IDX_W];
    dec_now.immediate_16 =
      issue_instr[rsc_pkg::IMMEDIATE_16_LSB +: rsc_pkg::IMMEDIATE_16_W];
    dec_now.op = rsc_pkg::OPK_NONE;
    // RULE12: primary opcode first
    case (op_field)
      rsc_pkg::OP_ORI:   dec_now.op = rsc_pkg::OPK_ORI;
      rsc_pkg::OP_RDPRS: dec_now.op = rsc_pkg::OPK_RDPRS;
      rsc_pkg::OP_RTYPE:
      begin
        // RULE12: extended opcode selects R-type
        case (opx_field)
          rsc_pkg::OPX_RDCTL: dec_now.op = rsc_pkg::OPK_RDCTL;
          rsc_pkg::OPX_RET:   dec_now.op = rsc_pkg::OPK_RET;
          rsc_pkg::OPX_ROL:   dec_now.op = rsc_pkg::OPK_ROL;
          rsc_pkg::OPX_ROLI:  dec_now.op = rsc_pkg::OPK_ROLI;
          rsc_pkg::OPX_ROR:   dec_now.op = rsc_pkg::OPK_ROR;
          rsc_pkg::OPX_SLL:   dec_now.op = rsc_pkg::OPK_SLL;
          default:            dec_now.op = rsc_pkg::OPK_NONE;
        endcase
      end
      default: dec_now.op = rsc_pkg::OPK_NONE;
    endcase
  end

  // ------------------------------------------------------------------
  // Operand shaping
  // ------------------------------------------------------------------
  always_comb
  begin
    // RULE1: upper half forced to zero
    imm_zext = {rsc_pkg::ZERO_HALF, dec.immediate_16};
    // RULE3: sign bit copied upward
    imm_sext = {{rsc_pkg::IMMEDIATE_16_W{dec.immediate_16[rsc_pkg::IMMEDIATE_16_W-1]}},
                dec.immediate_16};
    shift_kind   = rsc_pkg::SH_ROL;
    shift_amount = source_reg_b[rsc_pkg::IDX_W-1:0];
    case (dec.op)
      // RULE9: count from immediate field
      rsc_pkg::OPK_ROLI: shift_amount = dec.immediate_5;
      rsc_pkg::OPK_ROR:  shift_kind   = rsc_pkg::SH_ROR;
      rsc_pkg::OPK_SLL:  shift_kind   = rsc_pkg::SH_SLL;
      default:           shift_kind   = rsc_pkg::SH_ROL;
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencing and execute
  // ------------------------------------------------------------------
  always_comb
  begin
    next_state       = state;
    next_dec         = dec;
    next_issue_ready = issue_ready;
    next_rd_idx_a    = rd_idx_a;
    next_rd_idx_b    = rd_idx_b;
    next_rd_prev_set = rd_prev_set;
    next_ctl_idx     = ctl_idx;
    next_done        = 1'b0;
    next_unsupported = 1'b0;
    next_wb          = '0;
    next_pc_load     = 1'b0;
    next_pc_target   = pc_target;
    next_exc_valid   = 1'b0;
    next_exc_cause   = rsc_pkg::EXC_NONE;
    case (state)
      rsc_pkg::ST_IDLE:
      begin
        if (issue_valid)
        begin
          next_state       = rsc_pkg::ST_OPER;
          next_issue_ready = 1'b0;
          next_dec         = dec_now;
          next_rd_idx_a    = dec_now.a;
          next_rd_idx_b    = dec_now.b;
          // RULE4: set chosen by previous-set field
          next_rd_prev_set = prev_set;
          next_ctl_idx     = dec_now.immediate_5;
        end
      end
      rsc_pkg::ST_OPER:
      begin
        next_state = rsc_pkg::ST_DONE;
        next_done  = 1'b1;
        case (dec.op)
          rsc_pkg::OPK_ORI:
          begin
            // RULE1: OR into register B
            next_wb.en   = 1'b1;
            next_wb.idx  = dec.b;
            next_wb.data = source_reg_a | imm_zext;
          end
          rsc_pkg::OPK_RDCTL:
          begin
            // RULE2: user mode traps instead of reading
            if (!supervisor)
            begin
              next_exc_valid = 1'b1;
              next_exc_cause = rsc_pkg::EXC_SUPER;
            end
            else
            begin
              next_wb.en   = 1'b1;
              next_wb.idx  = dec.c;
              next_wb.data = control_reg_n;
            end
          end
          rsc_pkg::OPK_RDPRS:
          begin
            // RULE5: illegal wins over privilege
            if (!shadow_sets_present)
            begin
              next_exc_valid = 1'b1;
              next_exc_cause = rsc_pkg::EXC_ILLEGAL;
            end
            else if (!supervisor)
            begin
              next_exc_valid = 1'b1;
              next_exc_cause = rsc_pkg::EXC_SUPER;
            end
            else
            begin
              // RULE3: sum lands in current set B
              next_wb.en   = 1'b1;
              next_wb.idx  = dec.b;
              next_wb.data = prev_reg_a + imm_sext;
            end
          end
          rsc_pkg::OPK_RET:
          begin
            // RULE7: low target bits must be clear
            if (source_reg_a[rsc_pkg::ALIGN_W-1:0] != rsc_pkg::ALIGN_OK)
            begin
              next_exc_valid = 1'b1;
              next_exc_cause = rsc_pkg::EXC_MISALIGN;
            end
            else
            begin
              // RULE6: jump to return address
              next_pc_load   = 1'b1;
              next_pc_target = source_reg_a;
            end
          end
          rsc_pkg::OPK_ROL,
          rsc_pkg::OPK_ROLI,
          rsc_pkg::OPK_ROR,
          rsc_pkg::OPK_SLL:
          begin
            // RULE8: shifter result to register C
            next_wb.en   = 1'b1;
            next_wb.idx  = dec.c;
            next_wb.data = shift_out;
          end
          default:
          begin
            next_unsupported = 1'b1;
          end
        endcase
      end
      rsc_pkg::ST_DONE:
      begin
        next_state       = rsc_pkg::ST_IDLE;
        next_issue_ready = 1'b1;
      end
      default:
      begin
        next_state       = rsc_pkg::ST_IDLE;
        next_issue_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state       <= rsc_pkg::ST_IDLE;
      dec         <= '0;
      issue_ready <= 1'b1;
      rd_idx_a    <= '0;
      rd_idx_b    <= '0;
      rd_prev_set <= rsc_pkg::SET_RESET;
      ctl_idx     <= '0;
      done        <= 1'b0;
      unsupported <= 1'b0;
      wb          <= '0;
      pc_load     <= 1'b0;
      pc_target   <= rsc_pkg::ZERO_WORD;
      exc_valid   <= 1'b0;
      exc_cause   <= rsc_pkg::EXC_NONE;
    end
    else
    begin
      state       <= next_state;
      dec         <= next_dec;
      issue_ready <= next_issue_ready;
      rd_idx_a    <= next_rd_idx_a;
      rd_idx_b    <= next_rd_idx_b;
      rd_prev_set <= next_rd_prev_set;
      ctl_idx     <= next_ctl_idx;
      done        <= next_done;
      unsupported <= next_unsupported;
      wb          <= next_wb;
      pc_load     <= next_pc_load;
      pc_target   <= next_pc_target;
      exc_valid   <= next_exc_valid;
      exc_cause   <= next_exc_cause;
    end
  end

endmodule : rsc_exec

// *** rsc_pkg.sv ***
// Constants, encodings and carrier types for the rotate/shift/control
// read execute slice. Used by every design file of the slice.
package rsc_pkg;

  localparam int unsigned WORD_W    = 32;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned SET_W     = 6;
  localparam int unsigned OP_W      = 6;
  localparam int unsigned IMMEDIATE_16_W   = 16;
  localparam int unsigned ALIGN_W   = 2;

  // Instruction word field positions
  localparam int unsigned A_LSB     = 27;
  localparam int unsigned B_LSB     = 22;
  localparam int unsigned C_LSB     = 17;
  localparam int unsigned OPX_LSB   = 11;
  localparam int unsigned IMMEDIATE_5_LSB  = 6;
  localparam int unsigned IMMEDIATE_16_LSB = 6;
  localparam int unsigned OP_LSB    = 0;

  // Primary and extended opcodes
  localparam logic [OP_W-1:0] OP_RTYPE = 6'h3A;
  localparam logic [OP_W-1:0] OP_ORI   = 6'h14;
  localparam logic [OP_W-1:0] OP_RDPRS = 6'h38;
  localparam logic [OP_W-1:0] OPX_RDCTL = 6'h26;
  localparam logic [OP_W-1:0] OPX_RET   = 6'h05;
  localparam logic [OP_W-1:0] OPX_ROL   = 6'h03;
  localparam logic [OP_W-1:0] OPX_ROLI  = 6'h02;
  localparam logic [OP_W-1:0] OPX_ROR   = 6'h0B;
  localparam logic [OP_W-1:0] OPX_SLL   = 6'h13;

  localparam logic [IDX_W-1:0]   RETURN_ADDRESS_REGISTER = 5'h1F;
  localparam logic [ALIGN_W-1:0] ALIGN_OK   = 2'h0;
  localparam logic [IMMEDIATE_16_W-1:0] ZERO_HALF  = 16'h0000;
  localparam logic [WORD_W-1:0]  ZERO_WORD  = 32'h0000_0000;
  localparam logic [SET_W-1:0]   SET_RESET  = 6'h00;

  typedef enum logic [3:0] {
    OPK_NONE  = 4'h0,
    OPK_ORI   = 4'h1,
    OPK_RDCTL = 4'h2,
    OPK_RDPRS = 4'h3,
    OPK_RET   = 4'h4,
    OPK_ROL   = 4'h5,
    OPK_ROLI  = 4'h6,
    OPK_ROR   = 4'h7,
    OPK_SLL   = 4'h8
  } rsc_op_t;

  typedef enum logic [1:0] {
    EXC_NONE     = 2'h0,
    EXC_SUPER    = 2'h1,
    EXC_ILLEGAL  = 2'h2,
    EXC_MISALIGN = 2'h3
  } rsc_exc_t;

  typedef enum logic [1:0] {
    SH_ROL = 2'h0,
    SH_ROR = 2'h1,
    SH_SLL = 2'h2
  } rsc_shift_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPER = 2'b01,
    ST_DONE = 2'b10
  } rsc_state_t;

  typedef struct packed {
    rsc_op_t              op;
    logic [IDX_W-1:0]     a;
    logic [IDX_W-1:0]     b;
    logic [IDX_W-1:0]     c;
    logic [IDX_W-1:0]     immediate_5;
    logic [IMMEDIATE_16_W-1:0]   immediate_16;
  } rsc_dec_t;

  typedef struct packed {
    logic                 en;
    logic [IDX_W-1:0]     idx;
    logic [WORD_W-1:0]    data;
  } rsc_wb_t;

endpackage : rsc_pkg

// *** rsc_shifter.sv ***
// Combinational rotate and logical left shift of one 32-bit word.
// Count is already reduced to five bits by the caller.
`timescale 1ns/10ps
module rsc_shifter
(
  input  wire logic [rsc_pkg::WORD_W-1:0] value,
  input  wire logic [rsc_pkg::IDX_W-1:0]  amount,
  input  wire rsc_pkg::rsc_shift_t        kind,
  output      logic [rsc_pkg::WORD_W-1:0] result
);

  logic [2*rsc_pkg::WORD_W-1:0] dbl_left;
  logic [2*rsc_pkg::WORD_W-1:0] dbl_right;

  // Doubled word makes wrapped bits fall out of the shift
  always_comb
  begin
    dbl_left  = {value, value} << amount;
    dbl_right = {value, value} >> amount;
    case (kind)
      // RULE8: top bits re-enter low
      rsc_pkg::SH_ROL: result = dbl_left[2*rsc_pkg::WORD_W-1:rsc_pkg::WORD_W];
      // RULE10: low bits re-enter top
      rsc_pkg::SH_ROR: result = dbl_right[rsc_pkg::WORD_W-1:0];
      // RULE11: zero fill from bottom
      rsc_pkg::SH_SLL: result = value << amount;
      default:         result = value;
    endcase
  end

endmodule : rsc_shifter

// *** rsc_set_track.sv ***
// Current and previous register set tracking.
// Exception entry and software writes come from logic on the same clock.
`timescale 1ns/10ps
module rsc_set_track
(
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       set_switch,
  input  wire logic [rsc_pkg::SET_W-1:0]  set_switch_to,
  input  wire logic                       prs_write,
  input  wire logic [rsc_pkg::SET_W-1:0]  prs_write_value,
  output      logic [rsc_pkg::SET_W-1:0]  cur_set,
  output      logic [rsc_pkg::SET_W-1:0]  prev_set
);

  logic [rsc_pkg::SET_W-1:0] next_cur_set;
  logic [rsc_pkg::SET_W-1:0] next_prev_set;

  always_comb
  begin
    next_cur_set  = cur_set;
    next_prev_set = prev_set;
    // RULE4: remember set left by exception
    if (set_switch)
    begin
      next_prev_set = cur_set;
      next_cur_set  = set_switch_to;
    end
    // RULE4: software may pick any set
    else if (prs_write)
    begin
      next_prev_set = prs_write_value;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_set  <= rsc_pkg::SET_RESET;
      prev_set <= rsc_pkg::SET_RESET;
    end
    else
    begin
      cur_set  <= next_cur_set;
      prev_set <= next_prev_set;
    end
  end

endmodule : rsc_set_track

// *** rsc_exec_asserts.sv ***
// Port checker for rsc_exec: issue timing, pulses, exceptions.
// Assumes one domain on mclk with active-low rst_b.
`timescale 1ns/10ps
module rsc_exec_asserts
(
  input wire logic                       mclk,
  input wire logic                       rst_b,
  input wire logic                       issue_valid,
  input wire logic [rsc_pkg::WORD_W-1:0] issue_instr,
  input wire logic                       supervisor,
  input wire logic                       shadow_sets_present,
  input wire logic                       issue_ready,
  input wire logic [rsc_pkg::IDX_W-1:0]  rd_idx_a,
  input wire logic                       done,
  input wire logic                       unsupported,
  input wire rsc_pkg::rsc_wb_t           wb,
  input wire logic                       pc_load,
  input wire logic [rsc_pkg::WORD_W-1:0] pc_target,
  input wire logic                       exc_valid,
  input wire rsc_pkg::rsc_exc_t          exc_cause
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic take;
  logic is_r;
  assign take = issue_valid && issue_ready;
  assign is_r = issue_instr[5:0] == rsc_pkg::OP_RTYPE;

  a_done_two_after: assert property (take |-> ##2 done)
    else $error("done not two cycles after take");
  a_ready_busy: assert property
    (take |=> !issue_ready ##1 !issue_ready ##1 issue_ready)
    else $error("issue_ready sequence wrong after take");
  a_pulses_with_done: assert property
    ((wb.en || pc_load || exc_valid || unsupported) |-> done)
    else $error("result pulse without done");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_field_a: assert property
    (take |=> rd_idx_a == $past(issue_instr[31:27]))
    else $error("rd_idx_a not the A field");
  a_ret_aligned: assert property
    (pc_load |-> pc_target[1:0] == rsc_pkg::ALIGN_OK)
    else $error("branch to misaligned target");
  a_ret_outcome: assert property
    (take && is_r && issue_instr[16:11] == rsc_pkg::OPX_RET
     |-> ##2 (pc_load != exc_valid))
    else $error("return neither branched nor faulted");
  a_rdctl_user: assert property
    (take && is_r && issue_instr[16:11] == rsc_pkg::OPX_RDCTL
     ##1 !supervisor |=> exc_valid && exc_cause == rsc_pkg::EXC_SUPER)
    else $error("control read in user mode not refused");
  a_rdprs_illegal: assert property
    (take && issue_instr[5:0] == rsc_pkg::OP_RDPRS ##1 !shadow_sets_present
     |=> exc_valid && exc_cause == rsc_pkg::EXC_ILLEGAL)
    else $error("previous-set read without sets not illegal");
  a_exc_no_wb: assert property (exc_valid |-> !wb.en && !pc_load)
    else $error("exception with write or branch");

  c_wb: cover property (wb.en);
  c_branch: cover property (pc_load);
  c_misalign: cover property (exc_valid && exc_cause == rsc_pkg::EXC_MISALIGN);
endmodule : rsc_exec_asserts

bind rsc_exec rsc_exec_asserts u_chk
(
  .mclk, .rst_b, .issue_valid, .issue_instr, .supervisor,
  .shadow_sets_present, .issue_ready, .rd_idx_a, .done, .unsupported,
  .wb, .pc_load, .pc_target, .exc_valid, .exc_cause
);

// *** test_rsc_exec.sv ***
// Bench for rsc_exec: drives fetch, operands and set events by hand.
// Operands are presented in the cycle after each take.
`timescale 1ns/10ps
module test_rsc_exec;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              issue_valid = 1'b0;
  logic              supervisor = 1'b0;
  logic              shadow_sets_present = 1'b0;
  logic              set_switch = 1'b0;
  logic              prs_write = 1'b0;
  logic [31:0]       issue_instr = 32'h0;
  logic [31:0]       source_reg_a = 32'h0;
  logic [31:0]       source_reg_b = 32'h0;
  logic [31:0]       prev_reg_a = 32'h0;
  logic [31:0]       control_reg_n = 32'h0;
  logic [5:0]        set_switch_to = 6'h0;
  logic [5:0]        prs_write_value = 6'h0;
  logic              issue_ready, done, unsupported, pc_load, exc_valid;
  logic [4:0]        rd_idx_a, rd_idx_b, ctl_idx, r_ia, r_ci, r_ib;
  logic [5:0]        rd_prev_set, cur_set, r_ps;
  logic [31:0]       pc_target, r_pc;
  rsc_pkg::rsc_wb_t  wb, r_wb;
  rsc_pkg::rsc_exc_t exc_cause, r_cause;
  logic              r_done, r_uns, r_pcl, r_exc;
  int                fail_count = 0;
  int                n_checks = 0;
  int                cycles = 0;

  rsc_exec uut
  (
    .mclk, .rst_b, .issue_valid, .issue_instr, .supervisor,
    .shadow_sets_present, .source_reg_a, .source_reg_b, .prev_reg_a,
    .control_reg_n, .set_switch, .set_switch_to, .prs_write,
    .prs_write_value, .issue_ready, .rd_idx_a, .rd_idx_b, .rd_prev_set,
    .ctl_idx, .cur_set, .done, .unsupported, .wb, .pc_load, .pc_target,
    .exc_valid, .exc_cause
  );

  always #2 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] rt(input logic [4:0] a, b, c,
    input logic [5:0] x, input logic [4:0] n);
    return {a, b, c, x, n, rsc_pkg::OP_RTYPE};
  endfunction : rt

  function automatic logic [31:0] it(input logic [4:0] a, b,
    input logic [15:0] imm, input logic [5:0] op);
    return {a, b, imm, op};
  endfunction : it

  function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
    return (v << n) | (v >> (32 - n));
  endfunction : rotl

  // One instruction: take, operands in OPER cycle, capture results
  task automatic run(input logic [31:0] ins, a, b, input logic sup, shd);
    issue_valid <= 1'b1;
    issue_instr <= ins;
    @(posedge mclk);
    issue_valid <= 1'b0;
    source_reg_a <= a;
    source_reg_b <= b;
    prev_reg_a <= ~a;
    control_reg_n <= {a[15:0], a[31:16]};
    supervisor <= sup;
    shadow_sets_present <= shd;
    #1;
    r_ia = rd_idx_a;
    r_ci = ctl_idx;
    r_ib = rd_idx_b;
    r_ps = rd_prev_set;
    @(posedge mclk);
    #1;
    {r_done, r_uns, r_pcl, r_exc} = {done, unsupported, pc_load, exc_valid};
    {r_wb, r_cause, r_pc} = {wb, exc_cause, pc_target};
    @(posedge mclk);
  endtask : run

  task automatic expect_res(input logic en, input logic [4:0] idx,
    input logic [31:0] d, input rsc_pkg::rsc_exc_t ex = rsc_pkg::EXC_NONE);
    chk("done", 32'h1, {31'h0, r_done});
    chk("wb_en", {31'h0, en}, {31'h0, r_wb.en});
    if (en)
      chk("wb_idx", {27'h0, idx}, {27'h0, r_wb.idx});
    if (en)
      chk("wb_data", d, r_wb.data);
    chk("exc_valid", {31'h0, ex != rsc_pkg::EXC_NONE}, {31'h0, r_exc});
    if (ex != rsc_pkg::EXC_NONE)
      chk("exc_cause", {30'h0, ex}, {30'h0, r_cause});
  endtask : expect_res

  task automatic pulse(input logic sw, input logic [5:0] to,
    input logic pw, input logic [5:0] v);
    set_switch <= sw;
    set_switch_to <= to;
    prs_write <= pw;
    prs_write_value <= v;
    @(posedge mclk);
    set_switch <= 1'b0;
    prs_write <= 1'b0;
    @(posedge mclk);
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // zero-extended or
  task automatic t_ori;
    run(it(5'h07, 5'h06, 16'h8001, rsc_pkg::OP_ORI), 32'hF0F00000,
        32'h0, 1'b0, 1'b0);
    expect_res(1'b1, 5'h06, 32'hF0F08001, rsc_pkg::EXC_NONE);
  endtask : t_ori

  task automatic t_rdctl;
    for (int s = 0; s < 2; s++)
    begin
      run(rt(5'h0, 5'h0, 5'h03, rsc_pkg::OPX_RDCTL, 5'h1D), 32'h12345678,
          32'h0, s[0], 1'b1);
      chk("ctl_idx", 32'h1D, {27'h0, r_ci});
      if (s == 1)
        expect_res(1'b1, 5'h03, 32'h56781234, rsc_pkg::EXC_NONE);
      else
        expect_res(1'b0, 5'h0, 32'h0, rsc_pkg::EXC_SUPER);
    end
  endtask : t_rdctl

  task automatic t_rdprs;
    for (int i = 0; i < 4; i++)
    begin
      run(it(5'h07, 5'h06, 16'hFFF0, rsc_pkg::OP_RDPRS), 32'h100, 32'h0,
          i[0], i[1]);
      if (!i[1])
        expect_res(1'b0, 5'h0, 32'h0, rsc_pkg::EXC_ILLEGAL);
      else if (!i[0])
        expect_res(1'b0, 5'h0, 32'h0, rsc_pkg::EXC_SUPER);
      else
        expect_res(1'b1, 5'h06, 32'hFFFFFEEF, rsc_pkg::EXC_NONE);
    end
  endtask : t_rdprs

  task automatic prs_run(input logic [5:0] e);
    run(it(5'h07, 5'h06, 16'h0001, rsc_pkg::OP_RDPRS), 32'h0, 32'h0,
        1'b1, 1'b1);
    chk("rd_prev_set", {26'h0, e}, {26'h0, r_ps});
  endtask : prs_run

  task automatic t_sets;
    pulse(1'b1, 6'h05, 1'b0, 6'h00);
    pulse(1'b1, 6'h09, 1'b0, 6'h00);
    prs_run(6'h05);
    pulse(1'b1, 6'h02, 1'b1, 6'h07);
    chk("cur_set", 32'h2, {26'h0, cur_set});
    prs_run(6'h09);
    pulse(1'b0, 6'h02, 1'b1, 6'h03);
    prs_run(6'h03);
  endtask : t_sets

  task automatic t_ret;
    logic [31:0] t [3] = '{32'h00001234, 32'h00001236, 32'h00001235};
    foreach (t[i])
    begin
      run(rt(5'h1F, 5'h0, 5'h0, rsc_pkg::OPX_RET, 5'h0), t[i], 32'h0,
          1'b0, 1'b0);
      chk("rd_idx_a", 32'h1F, {27'h0, r_ia});
      chk("pc_load", {31'h0, i == 0}, {31'h0, r_pcl});
      if (i == 0)
        chk("pc_target", t[i], r_pc);
      expect_res(1'b0, 5'h0, 32'h0, i == 0 ? rsc_pkg::EXC_NONE
                 : rsc_pkg::EXC_MISALIGN);
    end
  endtask : t_ret

  task automatic t_shift;
    logic [5:0]  ops [4];
    int          ks [3] = '{0, 4, 31};
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    ops = '{rsc_pkg::OPX_ROL, rsc_pkg::OPX_ROR, rsc_pkg::OPX_SLL,
            rsc_pkg::OPX_ROLI};
    a = 32'h80000F01;
    foreach (ops[i])
      foreach (ks[j])
      begin
        b = 32'hFFFFFFE0 | ks[j];
        case (i)
          0: e = rotl(a, ks[j]);
          1: e = rotl(a, 32 - ks[j]);
          2: e = a << ks[j];
          default: e = rotl(a, ks[j]);
        endcase
        run(rt(5'h07, i == 3 ? 5'h00 : 5'h08, 5'h06, ops[i],
            i == 3 ? b[4:0] : 5'h00), a, i == 3 ? ~b : b, 1'b0, 1'b0);
        chk("rd_idx_b", {27'h0, i == 3 ? 5'h00 : 5'h08}, {27'h0, r_ib});
        expect_res(1'b1, 5'h06, e);
      end
  endtask : t_shift

  task automatic t_unknown;
    run(it(5'h07, 5'h06, 16'h1234, 6'h3F), 32'h1, 32'h1, 1'b1, 1'b1);
    chk("unsupported", 32'h1, {31'h0, r_uns});
    expect_res(1'b0, 5'h0, 32'h0, rsc_pkg::EXC_NONE);
  endtask : t_unknown

  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    chk("issue_ready", 32'h1, {31'h0, issue_ready});
    chk("pc_target", 32'h0, pc_target);
    @(posedge mclk);
    t_ori;
    t_rdctl;
    t_rdprs;
    t_sets;
    t_ret;
    t_shift;
    t_unknown;
    report_and_stop;
  end
endmodule : test_rsc_exec
